// *** hw/pss_power_switchover.sv ***
// Purpose : power state sequencer, battery-low comparator flag, access gating, trickle decode
// Assumes : comparator indications are asynchronous levels; host accesses arrive as strobes
// Notes   : one clock, synchronous active-low reset
`include "pss_defs.svh"
`default_nettype none

module pss_power_switchover #(
  parameter int POWER_UP_DELAY_CYCLES = `PSS_POWER_UP_DELAY_CYCLES
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // analog comparator indications
  input  wire pss_pkg::pss_supply_type supplyIn,
  // register access from the serial interface
  input  wire logic                 regWrStb,
  input  wire logic                 regRdStb,
  input  wire logic [7:0]           regAddr,
  input  wire logic [7:0]           regWrData,
  output logic      [7:0]           regRdData,
  output logic                      regRdValid,
  // power and analog control
  output pss_pkg::pss_state_type    powerState,
  output logic                      ifaceEnable,
  output logic                      oscRcSelect,
  output logic [3:0]                thresholdSelect,
  output pss_pkg::pss_charger_type  charger,
  output logic                      extInputEnable,
  output logic                      wdInputEnable,
  output logic                      clkOutEnable,
  // pins
  output logic                      freqOutIrqPin,
  output logic                      irq
);

  localparam int CW = $clog2(POWER_UP_DELAY_CYCLES + 1);

  function automatic pss_pkg::pss_charger_type decodeCharger(input logic [7:0] trk);
    pss_pkg::pss_charger_type c;
    c.enable         = (trk[7:4] == `PSS_CHARGER_KEY)
                       && (trk[3:2] == `PSS_DIODE_PLAIN || trk[3:2] == `PSS_DIODE_SERIES)
                       && (trk[1:0] != `PSS_RES_NONE);
    c.diodeInsert    = c.enable && (trk[3:2] == `PSS_DIODE_SERIES);
    c.resistorSelect = c.enable ? trk[1:0] : `PSS_RES_NONE;
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  pss_pkg::pss_supply_type syncA_ff;
  pss_pkg::pss_supply_type sup_ff;

  // comparators are analog and asynchronous, hence two stages
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      syncA_ff <= '0;
      sup_ff   <= '0;
    end else begin
      syncA_ff <= supplyIn;
      sup_ff   <= syncA_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power state machine

  pss_pkg::pss_state_type state_ff;
  pss_pkg::pss_state_type nxt_state;
  logic                   swReset;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pss_pkg::PSS_RESET: begin
        // a backup supply alone keeps the part in reset to spare the cell
        if (sup_ff.mainAboveStart) begin
          nxt_state = pss_pkg::PSS_MAIN;
        end
      end
      pss_pkg::PSS_MAIN: begin
        if (!sup_ff.mainAboveReset && !sup_ff.backupAboveSw) begin
          nxt_state = pss_pkg::PSS_RESET;
        end else if (!sup_ff.mainAboveSwFall && sup_ff.backupAboveSw) begin
          nxt_state = pss_pkg::PSS_BACKUP;
        end
      end
      pss_pkg::PSS_BACKUP: begin
        if (!sup_ff.backupAboveReset) begin
          nxt_state = pss_pkg::PSS_RESET;
        end else if (sup_ff.mainAboveSwRise) begin
          nxt_state = pss_pkg::PSS_MAIN;
        end
      end
      default: nxt_state = pss_pkg::PSS_RESET;
    endcase
    if (swReset) begin
      nxt_state = pss_pkg::PSS_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_ff <= pss_pkg::PSS_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers, power-up delay, comparator flag

  logic [7:0]    status_ff, irqMask_ff, oscCtrl_ff, cfgKey_ff, trickle_ff;
  logic [7:0]    cmpCfg_ff, batmode_ff, outCtrl_ff, rdData_ff;
  logic [7:0]    nxt_status, nxt_irqMask, nxt_oscCtrl, nxt_cfgKey, nxt_trickle;
  logic [7:0]    nxt_cmpCfg, nxt_batmode, nxt_outCtrl, nxt_rdData;
  logic          rdValid_ff, nxt_rdValid, pudelDone_ff, nxt_pudelDone;
  logic          prevRef_ff, nxt_prevRef;
  logic [CW-1:0] pudelCnt_ff, nxt_pudelCnt;
  logic          inReset, inBackup, accessOpen, cmpState, blEvent, wrHit;

  assign inReset    = (state_ff == pss_pkg::PSS_RESET);
  assign inBackup   = (state_ff == pss_pkg::PSS_BACKUP);
  assign accessOpen = pudelDone_ff && !inReset
                      && !(inBackup && !batmode_ff[`PSS_BIT_IFACE_BKP]);
  assign cmpState   = cmpCfg_ff[`PSS_BIT_POLARITY] ? sup_ff.backupAboveRiseRef
                                                   : sup_ff.backupAboveFallRef;
  // crossing detector compares against last cycle's synchronised level
  assign blEvent    = cmpCfg_ff[`PSS_BIT_POLARITY] ? (!prevRef_ff && cmpState)
                                                   : (prevRef_ff && !cmpState);
  assign wrHit      = regWrStb && accessOpen;
  assign swReset    = wrHit && regAddr == `PSS_OFS_CFG_KEY
                      && regWrData == `PSS_SW_RESET_KEY;

  always_comb begin
    nxt_status    = status_ff;
    nxt_irqMask   = irqMask_ff;
    nxt_oscCtrl   = oscCtrl_ff;
    nxt_cfgKey    = cfgKey_ff;
    nxt_trickle   = trickle_ff;
    nxt_cmpCfg    = cmpCfg_ff;
    nxt_batmode   = batmode_ff;
    nxt_outCtrl   = outCtrl_ff;
    nxt_rdData    = rdData_ff;
    nxt_rdValid   = 1'b0;
    nxt_prevRef   = cmpState;
    nxt_pudelCnt  = pudelCnt_ff;
    nxt_pudelDone = pudelDone_ff;
    // power-up delay runs only after a start from reset
    if (state_ff == pss_pkg::PSS_MAIN && !pudelDone_ff) begin
      if (pudelCnt_ff == CW'(POWER_UP_DELAY_CYCLES - 1)) begin
        nxt_pudelDone = 1'b1;
      end else begin
        nxt_pudelCnt = pudelCnt_ff + CW'(1);
      end
    end
    if (wrHit) begin
      case (regAddr)
        `PSS_OFS_STATUS:   nxt_status  = regWrData;
        `PSS_OFS_IRQ_MASK: nxt_irqMask = regWrData;
        `PSS_OFS_OSC_CTRL: nxt_oscCtrl = regWrData;
        `PSS_OFS_CFG_KEY:  nxt_cfgKey  = regWrData;
        `PSS_OFS_TRICKLE:  nxt_trickle = regWrData;
        `PSS_OFS_CMP_CFG:  nxt_cmpCfg  = regWrData;
        `PSS_OFS_BATMODE:  nxt_batmode = regWrData;
        `PSS_OFS_OUT_CTRL: nxt_outCtrl = regWrData;
        default: ;
      endcase
    end
    // hardware sets win over a software clear in the same cycle
    if (nxt_state == pss_pkg::PSS_BACKUP && !inBackup) begin
      nxt_status[`PSS_BIT_ON_BACKUP] = 1'b1;
    end
    if (blEvent) begin
      nxt_status[`PSS_BIT_BATT_LOW] = 1'b1;
    end
    if (regRdStb && accessOpen) begin
      nxt_rdValid = 1'b1;
      case (regAddr)
        `PSS_OFS_STATUS:   nxt_rdData = status_ff;
        `PSS_OFS_IRQ_MASK: nxt_rdData = irqMask_ff;
        `PSS_OFS_OSC_CTRL: nxt_rdData = oscCtrl_ff;
        `PSS_OFS_CFG_KEY:  nxt_rdData = cfgKey_ff;
        `PSS_OFS_TRICKLE:  nxt_rdData = trickle_ff;
        `PSS_OFS_CMP_CFG:  nxt_rdData = cmpCfg_ff;
        `PSS_OFS_BATMODE:  nxt_rdData = batmode_ff;
        `PSS_OFS_OUT_CTRL: nxt_rdData = outCtrl_ff;
        `PSS_OFS_CMP_STAT: nxt_rdData = {cmpState, 7'h00};
        default:           nxt_rdData = 8'h00;
      endcase
    end
  end

  // defaults load on the edge that enters reset, so no stale value is seen in reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b || nxt_state == pss_pkg::PSS_RESET) begin
      status_ff    <= `PSS_RST_STATUS;
      irqMask_ff   <= `PSS_RST_IRQ_MASK;
      oscCtrl_ff   <= `PSS_RST_OSC_CTRL;
      cfgKey_ff    <= `PSS_RST_CFG_KEY;
      trickle_ff   <= `PSS_RST_TRICKLE;
      cmpCfg_ff    <= `PSS_RST_CMP_CFG;
      batmode_ff   <= `PSS_RST_BATMODE;
      outCtrl_ff   <= `PSS_RST_OUT_CTRL;
      rdData_ff    <= 8'h00;
      rdValid_ff   <= 1'b0;
      prevRef_ff   <= 1'b0;
      pudelCnt_ff  <= '0;
      pudelDone_ff <= 1'b0;
    end else begin
      status_ff    <= nxt_status;
      irqMask_ff   <= nxt_irqMask;
      oscCtrl_ff   <= nxt_oscCtrl;
      cfgKey_ff    <= nxt_cfgKey;
      trickle_ff   <= nxt_trickle;
      cmpCfg_ff    <= nxt_cmpCfg;
      batmode_ff   <= nxt_batmode;
      outCtrl_ff   <= nxt_outCtrl;
      rdData_ff    <= nxt_rdData;
      rdValid_ff   <= nxt_rdValid;
      prevRef_ff   <= nxt_prevRef;
      pudelCnt_ff  <= nxt_pudelCnt;
      pudelDone_ff <= nxt_pudelDone;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign powerState      = state_ff;
  assign regRdData       = rdData_ff;
  assign regRdValid      = rdValid_ff;
  assign ifaceEnable     = accessOpen;
  assign oscRcSelect     = oscCtrl_ff[`PSS_BIT_OSC_RC]
                           || (inBackup && oscCtrl_ff[`PSS_BIT_AUTO_OSC]);
  assign thresholdSelect = cmpCfg_ff[7:4];
  assign charger         = decodeCharger(trickle_ff);
  // pins whose far side loses power are shut off in backup when their outCtrl_ff bit is clear; the reset value 8'h38 keeps all three on
  assign extInputEnable  = !inBackup || outCtrl_ff[`PSS_BIT_EXT_BKP];
  assign wdInputEnable   = !inBackup || outCtrl_ff[`PSS_BIT_WD_BKP];
  assign clkOutEnable    = !inBackup || outCtrl_ff[`PSS_BIT_CLKO_BKP];
  assign freqOutIrqPin   = pudelDone_ff;
  assign irq             = status_ff[`PSS_BIT_BATT_LOW] && irqMask_ff[`PSS_BIT_BL_IRQ_EN];

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_toBackup;
    state_ff == pss_pkg::PSS_MAIN && !sup_ff.mainAboveSwFall && sup_ff.backupAboveSw
    && sup_ff.mainAboveReset && !swReset;
  endsequence

  property p_resetStart;
    inReset && sup_ff.mainAboveStart && !swReset |=> state_ff == pss_pkg::PSS_MAIN;
  endproperty
  a_resetStart: assert property (p_resetStart) else $error("no start from reset");

  property p_resetHold;
    inReset && !sup_ff.mainAboveStart |=> inReset && status_ff == `PSS_RST_STATUS;
  endproperty
  a_resetHold: assert property (p_resetHold) else $error("left reset without main");

  property p_mainDrop;
    state_ff == pss_pkg::PSS_MAIN && !sup_ff.mainAboveReset && !sup_ff.backupAboveSw
    |=> inReset;
  endproperty
  a_mainDrop: assert property (p_mainDrop) else $error("main drop missed");

  property p_switchBackup;
    s_toBackup |=> inBackup ##0 status_ff[`PSS_BIT_ON_BACKUP];
  endproperty
  a_switchBackup: assert property (p_switchBackup) else $error("no backup switch");

  property p_backupLow;
    inBackup && !sup_ff.backupAboveReset |=> inReset ##1 status_ff == `PSS_RST_STATUS;
  endproperty
  a_backupLow: assert property (p_backupLow) else $error("backup low missed");

  property p_ifaceBlocked;
    inBackup && !batmode_ff[`PSS_BIT_IFACE_BKP] |=> !regRdValid;
  endproperty
  a_ifaceBlocked: assert property (p_ifaceBlocked) else $error("access in backup");

  property p_irq;
    blEvent && irqMask_ff[`PSS_BIT_BL_IRQ_EN] && !wrHit && nxt_state != pss_pkg::PSS_RESET
    |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_power_up_delay;
    inReset ##1 state_ff == pss_pkg::PSS_MAIN |-> !freqOutIrqPin ##1 !freqOutIrqPin;
  endproperty
  a_power_up_delay: assert property (p_power_up_delay) else $error("pin high too early");

  property p_swReset;
    swReset |=> inReset ##1 trickle_ff == `PSS_RST_TRICKLE;
  endproperty
  a_swReset: assert property (p_swReset) else $error("key reset failed");

  property p_charger;
    charger.enable |-> trickle_ff[7:4] == `PSS_CHARGER_KEY && trickle_ff[1:0] != 2'h0;
  endproperty
  a_charger: assert property (p_charger) else $error("charger enabled wrongly");

endmodule

`default_nettype wire

// *** shared/pss_defs.svh ***
// Purpose : offsets, field positions, reset values and timing for the power switchover block
// Assumes : 8-bit serial register space, 25 MHz system clock
// Notes   : definitions only
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

// register offsets
`define PSS_OFS_STATUS    8'h0F
`define PSS_OFS_IRQ_MASK  8'h12
`define PSS_OFS_OSC_CTRL  8'h1C
`define PSS_OFS_CFG_KEY   8'h1F
`define PSS_OFS_TRICKLE   8'h20
`define PSS_OFS_CMP_CFG   8'h21
`define PSS_OFS_BATMODE   8'h27
`define PSS_OFS_CMP_STAT  8'h2F
`define PSS_OFS_OUT_CTRL  8'h30

// field positions
`define PSS_BIT_ON_BACKUP   6
`define PSS_BIT_BATT_LOW    4
`define PSS_BIT_BL_IRQ_EN   4
`define PSS_BIT_OSC_RC      7
`define PSS_BIT_AUTO_OSC    4
`define PSS_BIT_IFACE_BKP   7
`define PSS_BIT_CMP_STATE   7
`define PSS_BIT_POLARITY    0
`define PSS_BIT_EXT_BKP     5
`define PSS_BIT_WD_BKP      4
`define PSS_BIT_CLKO_BKP    3

// reset values
`define PSS_RST_STATUS    8'h00
`define PSS_RST_IRQ_MASK  8'hE0
`define PSS_RST_OSC_CTRL  8'h00
`define PSS_RST_CFG_KEY   8'h00
`define PSS_RST_TRICKLE   8'h00
`define PSS_RST_CMP_CFG   8'h00
`define PSS_RST_BATMODE   8'h80
`define PSS_RST_OUT_CTRL  8'h38

// keys and codes
`define PSS_SW_RESET_KEY  8'h3C
`define PSS_CHARGER_KEY   4'hA
`define PSS_DIODE_PLAIN   2'h1
`define PSS_DIODE_SERIES  2'h2
`define PSS_RES_NONE      2'h0

// timing
`define PSS_CLK_KHZ       25000
`define PSS_POWER_UP_DELAY_MS      300
`define PSS_POWER_UP_DELAY_CYCLES  (`PSS_POWER_UP_DELAY_MS * `PSS_CLK_KHZ)

`endif

// *** shared/pss_pkg.sv ***
// Purpose : types shared by the power switchover block
// Assumes : nothing
// Notes   : constants live in pss_defs.svh
`default_nettype none

package pss_pkg;

  typedef enum logic [1:0] {
    PSS_RESET,
    PSS_MAIN,
    PSS_BACKUP
  } pss_state_type;

  // digital comparator indications, 1 = supply above the level
  typedef struct packed {
    logic mainAboveStart;
    logic mainAboveReset;
    logic mainAboveSwFall;
    logic mainAboveSwRise;
    logic backupAboveSw;
    logic backupAboveReset;
    logic backupAboveFallRef;
    logic backupAboveRiseRef;
  } pss_supply_type;

  typedef struct packed {
    logic       enable;
    logic       diodeInsert;
    logic [1:0] resistorSelect;
  } pss_charger_type;

endpackage

`default_nettype wire

// *** verification/pss_host_model.sv ***
// Purpose: host software model on the register strobe port
// Assumes: one byte per access, strobes launched at the falling edge
// Notes: released address and data lines show the inverse of the last value
`default_nettype none

module pss_host_model #(
  parameter int POLL_LIMIT = 40
) (
  // clock
  input  wire logic       clk_sys,
  // device answers
  input  wire logic       freqOutIrqPin,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid,
  // requests
  output logic            regWrStb,
  output logic            regRdStb,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  // no access until the pin is high
  task automatic waitReady(output bit ok);
    int n;
    n = 0;
    while (freqOutIrqPin !== 1'b1 && n < POLL_LIMIT) begin
      @(negedge clk_sys);
      n++;
    end
    ok = (freqOutIrqPin === 1'b1);
  endtask

  // one-cycle strobe; answer taken one edge later
  task automatic access(input bit wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output bit got);
    @(negedge clk_sys);
    regAddr = a;
    regWrData = d;
    regWrStb = wr;
    regRdStb = !wr;
    @(negedge clk_sys);
    got = (regRdValid === 1'b1);
    rd = regRdData;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
endmodule

`default_nettype wire

// *** verification/pss_power_switchover_bench.sv ***
// Purpose: self-checking bench for the power switchover block
// Assumes: power-up delay shortened to 20 cycles
// Notes: register model kept in an array, hardware-set flags added by hand
`include "pss_defs.svh"
`default_nettype none

module pss_power_switchover_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     clk_sys;
  logic                     rst_b;
  pss_pkg::pss_supply_type  supp;
  logic                     regWrStb;
  logic                     regRdStb;
  logic [7:0]               regAddr;
  logic [7:0]               regWrData;
  logic [7:0]               regRdData;
  logic                     regRdValid;
  pss_pkg::pss_state_type   powerState;
  logic                     ifaceEnable;
  logic                     oscRcSelect;
  logic [3:0]               thresholdSelect;
  pss_pkg::pss_charger_type charger;
  logic                     extInputEnable;
  logic                     wdInputEnable;
  logic                     clkOutEnable;
  logic                     freqOutIrqPin;
  logic                     irq;
  int                       errors;
  int                       nTests;
  int                       seed;
  logic [7:0]               mdl [0:255];
  logic [7:0]               offs [$];

  pss_power_switchover #(.POWER_UP_DELAY_CYCLES(20)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .supplyIn(supp),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .powerState(powerState), .ifaceEnable(ifaceEnable), .oscRcSelect(oscRcSelect),
    .thresholdSelect(thresholdSelect), .charger(charger),
    .extInputEnable(extInputEnable), .wdInputEnable(wdInputEnable),
    .clkOutEnable(clkOutEnable), .freqOutIrqPin(freqOutIrqPin), .irq(irq)
  );

  pss_host_model host (
    .clk_sys(clk_sys), .freqOutIrqPin(freqOutIrqPin), .regRdData(regRdData),
    .regRdValid(regRdValid), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regAddr(regAddr), .regWrData(regWrData)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic void resetModel();
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[`PSS_OFS_IRQ_MASK] = `PSS_RST_IRQ_MASK;
    mdl[`PSS_OFS_BATMODE] = `PSS_RST_BATMODE;
    mdl[`PSS_OFS_OUT_CTRL] = `PSS_RST_OUT_CTRL;
  endfunction

  // unmapped 8'h40 and read-only PSS_OFS_CMP_STAT keep their model value
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rd;
    bit g;
    host.access(1'b1, a, d, rd, g);
    if (a != 8'h40 && a != `PSS_OFS_CMP_STAT) mdl[a] = d;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] mask);
    logic [7:0] rd;
    bit g;
    host.access(1'b0, a, 8'h00, rd, g);
    chk("regRdValid", 8'h01, {7'h00, g});
    chk("regRdData", mdl[a] & mask, rd & mask);
  endtask

  // bound covers two sync stages plus the state update
  task automatic waitState(input pss_pkg::pss_state_type s);
    int n;
    n = 0;
    while (powerState !== s && n < 12) begin
      @(negedge clk_sys);
      n++;
    end
    chk("powerState", {6'h00, s}, {6'h00, powerState});
    if (n >= 12) summarize();
  endtask

  task automatic powerUp();
    bit ok;
    supp[7:4] = 4'hF;
    waitState(pss_pkg::PSS_MAIN);
    host.waitReady(ok);
    chk("ready", 8'h01, {7'h00, ok});
    if (!ok) summarize();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [7:0] rd;
    bit g;
    bit en;
    errors = 0;
    nTests = 0;
    seed = 67000;
    rst_b = 1'b0;
    supp = '0;
    offs = '{8'h0F, 8'h12, 8'h1F, 8'h20, 8'h21, 8'h27, 8'h30, 8'h40};
    resetModel();
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    supp.backupAboveSw = 1'b1;
    supp.backupAboveReset = 1'b1;
    supp.backupAboveFallRef = 1'b1;
    repeat (8) @(negedge clk_sys);
    waitState(pss_pkg::PSS_RESET);
    chk("freqOutIrqPin", 8'h00, {7'h00, freqOutIrqPin});
    supp[7:4] = 4'hF;
    waitState(pss_pkg::PSS_MAIN);
    chk("ifaceEnable", 8'h00, {7'h00, ifaceEnable});
    host.access(1'b1, `PSS_OFS_IRQ_MASK, 8'h10, rd, g);
    powerUp();
    foreach (offs[i]) rc(offs[i], 8'hFF);
    // every diode and resistor code under the key, then random bytes
    for (int i = 0; i < 24; i++) begin
      v = (i < 16) ? {4'hA, i[3:0]} : 8'($random(seed));
      w(`PSS_OFS_TRICKLE, v);
      en = v[7:4] == 4'hA && (v[3:2] == 2'h1 || v[3:2] == 2'h2) && v[1:0] != 2'h0;
      chk("chargerEnable", {7'h00, en}, {7'h00, charger.enable});
      if (en) chk("charger", {4'h0, en, v[3:2] == 2'h2, v[1:0]}, {4'h0, charger});
    end
    w(`PSS_OFS_OSC_CTRL, 8'h10);
    w(`PSS_OFS_OUT_CTRL, 8'h00);
    supp.backupAboveSw = 1'b0;
    repeat (6) @(negedge clk_sys);
    waitState(pss_pkg::PSS_MAIN);
    supp.backupAboveSw = 1'b1;
    repeat (3) @(negedge clk_sys);
    supp[7:4] = 4'h0;
    waitState(pss_pkg::PSS_BACKUP);
    mdl[`PSS_OFS_STATUS] = 8'h40;
    chk("oscRcSelect", 8'h01, {7'h00, oscRcSelect});
    chk("pinEnables", 8'h00, {5'h00, extInputEnable, wdInputEnable, clkOutEnable});
    chk("ifaceEnable", 8'h01, {7'h00, ifaceEnable});
    rc(`PSS_OFS_STATUS, 8'hFF);
    supp[7:4] = 4'hF;
    waitState(pss_pkg::PSS_MAIN);
    chk("oscRcSelect", 8'h00, {7'h00, oscRcSelect});
    w(`PSS_OFS_STATUS, 8'h00);
    w(`PSS_OFS_BATMODE, 8'h00);
    supp[7:4] = 4'h0;
    waitState(pss_pkg::PSS_BACKUP);
    chk("ifaceEnable", 8'h00, {7'h00, ifaceEnable});
    host.access(1'b0, `PSS_OFS_STATUS, 8'h00, rd, g);
    chk("refusedValid", 8'h00, {7'h00, g});
    supp.backupAboveReset = 1'b0;
    waitState(pss_pkg::PSS_RESET);
    chk("freqOutIrqPin", 8'h00, {7'h00, freqOutIrqPin});
    resetModel();
    supp.backupAboveReset = 1'b1;
    powerUp();
    foreach (offs[i]) rc(offs[i], 8'hFF);
    // falling detection: settle, clear, confirm, then cross
    w(`PSS_OFS_IRQ_MASK, 8'h10);
    w(`PSS_OFS_CMP_CFG, 8'h50);
    chk("thresholdSelect", 8'h05, {4'h0, thresholdSelect});
    repeat (5) @(negedge clk_sys);
    w(`PSS_OFS_STATUS, 8'h00);
    mdl[`PSS_OFS_CMP_STAT] = 8'h80;
    rc(`PSS_OFS_CMP_STAT, 8'h80);
    supp.backupAboveFallRef = 1'b0;
    repeat (5) @(negedge clk_sys);
    mdl[`PSS_OFS_STATUS] = 8'h10;
    rc(`PSS_OFS_STATUS, 8'hFF);
    chk("irq", 8'h01, {7'h00, irq});
    w(`PSS_OFS_IRQ_MASK, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    // rising detection with the opposite polarity
    w(`PSS_OFS_CMP_CFG, 8'h51);
    repeat (5) @(negedge clk_sys);
    w(`PSS_OFS_STATUS, 8'h00);
    mdl[`PSS_OFS_CMP_STAT] = 8'h00;
    rc(`PSS_OFS_CMP_STAT, 8'h80);
    supp.backupAboveRiseRef = 1'b1;
    repeat (5) @(negedge clk_sys);
    mdl[`PSS_OFS_STATUS] = 8'h10;
    rc(`PSS_OFS_STATUS, 8'hFF);
    w(8'h40, 8'hFF);
    rc(8'h40, 8'hFF);
    supp.backupAboveSw = 1'b0;
    supp[7:4] = 4'h0;
    waitState(pss_pkg::PSS_RESET);
    resetModel();
    powerUp();
    w(`PSS_OFS_CMP_CFG, 8'h51);
    w(`PSS_OFS_CFG_KEY, `PSS_SW_RESET_KEY);
    chk("powerState", {6'h00, pss_pkg::PSS_RESET}, {6'h00, powerState});
    resetModel();
    powerUp();
    foreach (offs[i]) rc(offs[i], 8'hFF);
    summarize();
  end
endmodule

`default_nettype wire
